// ==== pwmu_top.v ====
// Four-channel modulator unit with AXI4-Lite register access and LED pin drive
//
// Operation
// - Four independent modulator channels each make their own waveform.
// - Each channel holds a 10-bit starting count that software writes and reads back.
// - Each channel holds a 10-bit compare value, read and write, where its output flips.
// - Each channel's live 10-bit counter is read-only; writes to it do nothing.
// - One 12-bit read/write configuration register is shared by all four channels.
// - The configuration holds an enable per channel so each is set up on its own.
// - The configuration holds a clock select per channel and the counter runs on it.
// - The configuration holds a phase bit per channel that inverts that channel's waveform.
// - The four channel outputs can be routed to the four high-current LED pins.
// - On clock select 0, counting is paced by the shared 128 kHz low-power peripheral oscillator.
// - The peripheral clock request is high only while some channel is enabled.
//
// The AXI4-Lite slave port and the address map were decided locally.
`include "pwmu_regs.vh"

module pwmu_top #(
  parameter NUM_CH = 4,
  parameter CNT_W = `PWMU_CNT_W
) (
  input wire aclk,
  input wire aresetn,
  input wire [`PWMU_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`PWMU_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire lpo_clk_in,
  output wire lpo_clk_req,
  output wire [NUM_CH-1:0] led_pin_out,
  output wire [NUM_CH-1:0] led_pin_oe_n
);

  // Decode of a byte address: {valid, kind[1:0], index[1:0]}
  function [4:0] dec_addr;
    input [`PWMU_ADDR_W-1:0] a;
    reg [`PWMU_ADDR_W-1:0] low;
    begin
      low = a & (`PWMU_CH_STRIDE - 8'h01);
      dec_addr = 5'h00;
      if (a == `PWMU_CFG_OFF) begin
        dec_addr = {1'b1, `PWMU_KIND_GLOBAL, 2'h0};
      end else if (a == `PWMU_ROUTE_OFF) begin
        dec_addr = {1'b1, `PWMU_KIND_GLOBAL, 2'h1};
      end else if (a < `PWMU_CH_STRIDE * NUM_CH) begin
        if (low == `PWMU_START_OFF) begin
          dec_addr = {1'b1, `PWMU_KIND_START, a[5:4]};
        end else if (low == `PWMU_CMP_OFF) begin
          dec_addr = {1'b1, `PWMU_KIND_CMP, a[5:4]};
        end else if (low == `PWMU_LIVE_OFF) begin
          dec_addr = {1'b1, `PWMU_KIND_LIVE, a[5:4]};
        end
      end
    end
  endfunction

  // Byte-lane merge of write data into a stored word
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Software-visible state
  reg [CNT_W-1:0] start_ff [0:NUM_CH-1];
  reg [CNT_W-1:0] cmp_ff [0:NUM_CH-1];
  reg [`PWMU_CFG_W-1:0] cfg_ff;
  reg [NUM_CH-1:0] route_ff;

  // Bus handshake state
  reg awready_ff;
  reg wready_ff;
  reg [`PWMU_ADDR_W-1:0] awaddr_ff;
  reg aw_held_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg w_held_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // Oscillator edge detect and pin drive
  reg lpo_prev_ff;
  reg lpo_tick_ff;
  reg lpo_req_ff;
  reg [NUM_CH-1:0] pin_out_ff;
  reg [NUM_CH-1:0] pin_oe_n_ff;

  wire [NUM_CH-1:0] ch_en = cfg_ff[`PWMU_CFG_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] ch_clk_sel = cfg_ff[`PWMU_CFG_CLK_LSB +: NUM_CH];
  wire [NUM_CH-1:0] ch_phase = cfg_ff[`PWMU_CFG_PH_LSB +: NUM_CH];
  wire [NUM_CH-1:0] ch_wave;
  wire [CNT_W-1:0] ch_count [0:NUM_CH-1];

  wire aw_take = s_axi_awvalid & awready_ff;
  wire w_take = s_axi_wvalid & wready_ff;
  wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [4:0] wr_dec = dec_addr(awaddr_ff);
  // Write data merged by byte lane into each register's current contents
  wire [31:0] start_merge = lane_merge({22'h0, start_ff[wr_dec[1:0]]}, wdata_ff, wstrb_ff);
  wire [31:0] cmp_merge = lane_merge({22'h0, cmp_ff[wr_dec[1:0]]}, wdata_ff, wstrb_ff);
  wire [31:0] cfg_merge = lane_merge({20'h0, cfg_ff}, wdata_ff, wstrb_ff);
  wire [31:0] route_merge = lane_merge({28'h0, route_ff}, wdata_ff, wstrb_ff);
  wire ar_take = s_axi_arvalid & arready_ff;
  wire [4:0] rd_dec = dec_addr(s_axi_araddr);

  // Rising edge of the low-power oscillator paces counters on clock select 0
  always @(posedge aclk) begin
    if (!aresetn) begin
      lpo_prev_ff <= 1'b0;
      lpo_tick_ff <= 1'b0;
    end else begin
      lpo_prev_ff <= lpo_clk_in;
      lpo_tick_ff <= lpo_clk_in & ~lpo_prev_ff;
    end
  end

  // Oscillator is requested while any channel is enabled, whatever its clock select
  always @(posedge aclk) begin
    if (!aresetn) begin
      lpo_req_ff <= 1'b0;
    end else begin
      lpo_req_ff <= |ch_en;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      // Select 0: oscillator tick; select 1: every system clock
      wire ch_tick = ch_clk_sel[g] ? 1'b1 : lpo_tick_ff;

      pwmu_channel #(
        .CNT_W(CNT_W)
      ) u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ch_en[g]),
        .tick(ch_tick),
        .invert(ch_phase[g]),
        .start_val(start_ff[g]),
        .cmp_val(cmp_ff[g]),
        .count(ch_count[g]),
        .wave(ch_wave[g])
      );
    end
  endgenerate

  // Routed pin is driven (enable low); unrouted pin is released
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff <= {NUM_CH{1'b0}};
      pin_oe_n_ff <= {NUM_CH{1'b1}};
    end else begin
      pin_out_ff <= ch_wave & route_ff;
      pin_oe_n_ff <= ~route_ff;
    end
  end

  // Write address and data are accepted independently, one of each at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= {`PWMU_ADDR_W{1'b0}};
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      awready_ff <= ~aw_held_ff & ~aw_take & ~wr_fire;
      wready_ff <= ~w_held_ff & ~w_take & ~wr_fire;
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Register update and write response
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < NUM_CH; k = k + 1) begin
        start_ff[k] <= `PWMU_START_RST;
        cmp_ff[k] <= `PWMU_CMP_RST;
      end
      cfg_ff <= `PWMU_CFG_RST;
      route_ff <= `PWMU_ROUTE_RST;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PWMU_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_dec[4] ? `PWMU_RESP_OKAY : `PWMU_RESP_SLVERR;
        if (wr_dec[4]) begin
          case (wr_dec[3:2])
            `PWMU_KIND_START: begin
              start_ff[wr_dec[1:0]] <= start_merge[CNT_W-1:0];
            end
            `PWMU_KIND_CMP: begin
              cmp_ff[wr_dec[1:0]] <= cmp_merge[CNT_W-1:0];
            end
            `PWMU_KIND_LIVE: begin
              // Live counter is read-only: write is acknowledged and dropped
            end
            default: begin
              if (wr_dec[1:0] == 2'h0) begin
                cfg_ff <= cfg_merge[`PWMU_CFG_W-1:0];
              end else begin
                route_ff <= route_merge[NUM_CH-1:0];
              end
            end
          endcase
        end
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data registered with the valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `PWMU_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_dec[4] ? `PWMU_RESP_OKAY : `PWMU_RESP_SLVERR;
        rdata_ff <= 32'h00000000;
        if (rd_dec[4]) begin
          case (rd_dec[3:2])
            `PWMU_KIND_START: rdata_ff <= {22'h0, start_ff[rd_dec[1:0]]};
            `PWMU_KIND_CMP: rdata_ff <= {22'h0, cmp_ff[rd_dec[1:0]]};
            `PWMU_KIND_LIVE: rdata_ff <= {22'h0, ch_count[rd_dec[1:0]]};
            default: begin
              if (rd_dec[1:0] == 2'h0) begin
                rdata_ff <= {20'h0, cfg_ff};
              end else begin
                rdata_ff <= {28'h0, route_ff};
              end
            end
          endcase
        end
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end else if (~rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign lpo_clk_req = lpo_req_ff;
  assign led_pin_out = pin_out_ff;
  assign led_pin_oe_n = pin_oe_n_ff;

endmodule

// ==== pwmu_regs.vh ====
// Register map, field layout and reset values of the four-channel modulator unit
`ifndef PWMU_REGS_VH
`define PWMU_REGS_VH

`define PWMU_ADDR_W 8
`define PWMU_CH_STRIDE 8'h10
`define PWMU_START_OFF 8'h00
`define PWMU_CMP_OFF 8'h04
`define PWMU_LIVE_OFF 8'h08
`define PWMU_CFG_OFF 8'h40
`define PWMU_ROUTE_OFF 8'h44

`define PWMU_CNT_W 10
`define PWMU_CFG_W 12
`define PWMU_CFG_EN_LSB 0
`define PWMU_CFG_CLK_LSB 4
`define PWMU_CFG_PH_LSB 8

`define PWMU_START_RST 10'h000
`define PWMU_CMP_RST 10'h200
`define PWMU_CFG_RST 12'h000
`define PWMU_ROUTE_RST 4'h0

`define PWMU_KIND_START 2'h0
`define PWMU_KIND_CMP 2'h1
`define PWMU_KIND_LIVE 2'h2
`define PWMU_KIND_GLOBAL 2'h3

`define PWMU_RESP_OKAY 2'h0
`define PWMU_RESP_SLVERR 2'h2

`endif

// ==== pwmu_channel.v ====
// One modulator channel: reloading counter and compare-driven output level
`include "pwmu_regs.vh"

module pwmu_channel #(
  parameter CNT_W = `PWMU_CNT_W
) (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire tick,
  input wire invert,
  input wire [CNT_W-1:0] start_val,
  input wire [CNT_W-1:0] cmp_val,
  output wire [CNT_W-1:0] count,
  output wire wave
);

  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg level_ff;
  reg nxt_level;
  reg wave_ff;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_level = level_ff;
    if (!enable) begin
      // Idle channel parks on its starting value so enabling starts a clean period
      nxt_cnt = start_val;
      nxt_level = 1'b1;
    end else if (tick) begin
      if (cnt_ff == CNT_MAX) begin
        nxt_cnt = start_val;
        nxt_level = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (nxt_cnt == cmp_val) begin
        nxt_level = 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= `PWMU_START_RST;
      level_ff <= 1'b1;
      wave_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
      // Disabled channel rests low; phase bit inverts the waveform
      wave_ff <= enable & (nxt_level ^ invert);
    end
  end

  assign count = cnt_ff;
  assign wave = wave_ff;

endmodule

// ==== pwmu_top_asserts.sv ====
// Bus handshake and pin drive checks for the four-channel modulator unit
module pwmu_top_asserts #(
  parameter NUM_CH = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire lpo_clk_req,
  input wire [NUM_CH-1:0] led_pin_out,
  input wire [NUM_CH-1:0] led_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_W_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
  AST_B_DONE:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_R_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
  AST_R_DONE:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
  AST_R_RESP:
    assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0) else $error("bad read response");
  AST_R_WIDTH:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0) else $error("high bits set");
  AST_PIN_OE:
    assert property ((led_pin_out & led_pin_oe_n) == '0) else $error("pin high while released");
  AST_REQ_ON:
    assert property (led_pin_out != '0 |-> lpo_clk_req || $past(lpo_clk_req)
      || $past(lpo_clk_req, 2)) else $error("pin active without clock request");
  AST_REQ_OFF:
    assert property (!lpo_clk_req [*5] |-> led_pin_out == '0) else $error("idle unit drives pin");
endmodule

bind pwmu_top pwmu_top_asserts #(.NUM_CH(NUM_CH)) pwmu_top_asserts_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lpo_clk_req(lpo_clk_req),
  .led_pin_out(led_pin_out), .led_pin_oe_n(led_pin_oe_n)
);

// ==== pwmu_led_model.sv ====
// LED load on one pin: measures the last high and low run lengths
module pwmu_led_model #(
  parameter CH = 0
) (
  input wire aclk,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n,
  output int hi_len,
  output int lo_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  logic prev;
  int run;
  // A released pin is pulled up through the LED to the supply
  assign lvl = pin_oe_n[CH] ? 1'b1 : pin_out[CH];
  always @(posedge aclk) begin
    prev <= lvl;
    if (lvl !== prev) begin
      if (prev === 1'b1) hi_len <= run;
      else lo_len <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
  end
endmodule

// ==== tb_top.sv ====
// Register and waveform tests of the four-channel modulator unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lpo;
  logic awready, wready, bvalid, arready, rvalid, req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, pin_out, pin_oe_n;
  logic [1:0] bresp, rresp, r;
  int err_total, tests_run, hi_len, lo_len, c;
  always #5 aclk = ~aclk;
  pwmu_top pwmu_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lpo_clk_in(lpo),
    .lpo_clk_req(req), .led_pin_out(pin_out), .led_pin_oe_n(pin_oe_n));
  pwmu_led_model #(.CH(0)) pwmu_led_model_i (.aclk(aclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .hi_len(hi_len), .lo_len(lo_len));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo;
    err_total++;
    $display("FAIL handshake expected answer seen none");
    print_verdict;
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (i == 40) tmo;
    r = bresp;
    bready <= 0;
  endtask
  task rd(input [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (i == 40) tmo;
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task rchk(input [7:0] a, input [31:0] exp, input string nm);
    rd(a);
    chk(v, exp, nm);
  endtask
  task osc(input int n);
    repeat (n) begin
      @(posedge aclk);
      lpo <= 1;
      repeat (3) @(posedge aclk);
      lpo <= 0;
      repeat (3) @(posedge aclk);
    end
  endtask
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lpo} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (c = 0; c < 4; c++) begin
      rchk(8'(c * 16), 32'h0, "start reset");
      rchk(8'(c * 16 + 4), 32'h200, "compare reset");
    end
    rchk(8'h40, 32'h0, "config reset");
    chk(32'(req), 32'h0, "request at reset");
    $display("test reset values done");
    for (c = 0; c < 4; c++) begin
      wr(8'(c * 16), 32'hffff_fc00 + c, 4'hf);
      wr(8'(c * 16 + 4), 32'hffff_ffff - c, 4'hf);
      wr(8'(c * 16 + 8), 32'h155, 4'hf);
      chk(32'(r), 32'h0, "live write response");
    end
    for (c = 0; c < 4; c++) begin
      rchk(8'(c * 16), 32'(c), "start readback");
      rchk(8'(c * 16 + 4), 32'h3ff - c, "compare readback");
      rchk(8'(c * 16 + 8), 32'(c), "live unchanged");
    end
    wr(8'h04, 32'h0000_01aa, 4'h2);
    rchk(8'h04, 32'h1ff, "compare lane write");
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rchk(8'h40, 32'hfff, "config width");
    wr(8'h50, 32'h1, 4'hf);
    chk(32'(r), 32'h2, "unmapped write");
    rchk(8'h0c, 32'h0, "unmapped data");
    chk(32'(r), 32'h2, "unmapped read");
    $display("test register access done");
    wr(8'h40, 32'h0, 4'hf);
    wr(8'h00, 32'h3fe, 4'hf);
    wr(8'h40, 32'h001, 4'hf);
    rchk(8'h08, 32'h3fe, "live before tick");
    chk(32'(req), 32'h1, "request on enable");
    rchk(8'h18, 32'h1, "idle channel count");
    osc(3);
    rchk(8'h08, 32'h3ff, "live after reload");
    $display("test oscillator count done");
    wr(8'h00, 32'h3f0, 4'hf);
    wr(8'h04, 32'h3f4, 4'hf);
    wr(8'h44, 32'h1, 4'hf);
    rchk(8'h44, 32'h1, "route readback");
    wr(8'h40, 32'h011, 4'hf);
    repeat (60) @(posedge aclk);
    chk(32'(hi_len), 32'd4, "high run");
    chk(32'(lo_len), 32'd12, "low run");
    wr(8'h40, 32'h111, 4'hf);
    repeat (60) @(posedge aclk);
    chk(32'(hi_len), 32'd12, "inverted high run");
    chk(32'(lo_len), 32'd4, "inverted low run");
    $display("test waveform done");
    wr(8'h40, 32'h0, 4'hf);
    repeat (5) @(posedge aclk);
    chk(32'(req), 32'h0, "request off");
    chk(32'(pin_out), 32'h0, "pin idle");
    chk(32'(pin_oe_n), 32'he, "pin enable");
    $display("test disable done");
    print_verdict;
  end
endmodule
